/* File: verilog/fcpa_pkg.sv */
// Constants shared by the fault classifier and priority arbiter.
`default_nettype none
package fcpa_pkg;

	// ------------------------------------------------------------
	// Register offsets.
	// ------------------------------------------------------------
	localparam logic [11:0] OFS_CONFIG = 12'h000;
	localparam logic [11:0] OFS_MASKS = 12'h004;
	localparam logic [11:0] OFS_FSTAT = 12'h008;
	localparam logic [11:0] OFS_HCSR = 12'h00C;
	localparam logic [11:0] OFS_STATE = 12'h010;
	localparam logic [11:0] OFS_EXSTATE = 12'h014;
	localparam logic [11:0] OFS_PRIO_BASE = 12'h020;
	localparam logic [11:0] OFS_PRIO_LAST = 12'h040;

	// ------------------------------------------------------------
	// Field positions and reset values.
	// ------------------------------------------------------------
	localparam int CFG_MISALIGN_BIT = 0;
	localparam int CFG_ZDIV_BIT = 1;
	localparam int CFG_DEMOTE_BIT = 2;
	localparam int CFG_GROUP_LSB = 8;
	localparam int MSK_GLOBAL_BIT = 0;
	localparam int MSK_FAULT_BIT = 1;
	localparam int MSK_BASE_LSB = 8;
	localparam int PRIO_NS_BIT = 8;
	localparam int HCSR_PEND_LSB = 4;
	localparam int HCSR_ACT_LSB = 8;
	localparam int ST_NUM_LSB = 9;
	localparam int ST_VALID_BIT = 18;
	localparam int ST_TAKE_BIT = 19;
	localparam int ST_HSEC_BIT = 20;
	localparam int EX_ACT_LSB = 16;
	localparam logic [31:0] CONFIG_RST = 32'h0000_0000;
	localparam logic [31:0] MASKS_RST = 32'h0000_0000;
	localparam logic [7:0] PRIO_RST = 8'h00;

	// ------------------------------------------------------------
	// Fault status flag layout.
	// ------------------------------------------------------------
	localparam int NFLAG = 18;
	localparam int FL_BUS_LSB = 0;
	localparam int FL_USE_LSB = 4;
	localparam int FL_SEC_LSB = 11;
	localparam int FL_BADSTATE = 5;
	localparam int FL_MISALIGN = 9;
	localparam int FL_ZDIV = 10;

	// ------------------------------------------------------------
	// Exception slots, numbers and priority keys.
	// ------------------------------------------------------------
	localparam int NSLOT = 9;
	localparam int NIRQ = 4;
	localparam int SL_HARD = 0;
	localparam int SL_MEM = 1;
	localparam int SL_BUS = 2;
	localparam int SL_USE = 3;
	localparam int SL_SEC = 4;
	localparam int SL_IRQ = 5;
	localparam logic [8:0] EXC_HARD = 9'h003;
	localparam logic [8:0] EXC_IRQ_BASE = 9'h010;
	localparam logic [7:0] IMPL_MASK_MAIN = 8'hF0;
	localparam logic [7:0] IMPL_MASK_BASE = 8'hC0;
	localparam logic [7:0] GROUP_MASK_BASE = 8'hFE;
	localparam logic [8:0] KEY_FAULT_PRIORITY_MASK = 9'h000;
	localparam logic [8:0] KEY_HARD = 9'h000;
	localparam logic [8:0] KEY_GLOBAL_PRIORITY_MASK = 9'h001;
	localparam logic [8:0] KEY_IDLE = 9'h101;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Exception number held by a slot.
	function automatic logic [8:0] slot_num(input int i);
		if (i < SL_IRQ) begin
			return EXC_HARD + 9'(i);
		end
		return EXC_IRQ_BASE + 9'(i - SL_IRQ);
	endfunction

endpackage

`default_nettype wire

/* File: verilog/fcpa_top.sv */
// Fault classifier, exception state tracker and priority arbiter with an AXI4-Lite slave.
// Operation
// - Bus faults number 5 with four flags.
// - Usage faults number 6 with seven flags.
// - Misaligned and divide traps need enables.
// - Security faults number 7 with own flags.
// - No main: fault handler bits read zero.
// - No main: only hard fault is taken.
// - No main: security faults become secure hard.
// - Synchronous exceptions never active and pending.
// - Smaller priority value is more urgent.
// - Execution priority from actives, then masks.
// - Idle thread runs at least urgent level.
// - Preempt only on strictly smaller group.
// - Grouping field splits group and subpriority.
// - Unimplemented low priority bits read zero.
// - No main: fixed split, bits 5:0 zero.
// - Pick smallest group, subpriority, then number.
// - Secure wins a full tie.
// - Demotion halves non-secure group, adds 0x80.
`timescale 1ns/10ps
`default_nettype none

module fcpa_top #(
	parameter bit MAIN_EXT = 1'b1,
	parameter bit SEC_EXT = 1'b1
) (
	// Clock and reset.
	input wire logic SYS_CLK,
	input wire logic RESET_N,
	// AXI4-Lite slave.
	input wire logic [11:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [11:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Fault causes and interrupt requests from the core.
	input wire logic [17:0] FAULT_CAUSE,
	input wire logic INSTR_ISSUE,
	input wire logic INSTRUCTION_SET_STATE_BIT,
	input wire logic [3:0] IRQ_REQ,
	// Exception entry and return.
	output logic TAKE_REQ,
	output logic [3:0] TAKE_SLOT,
	output logic [8:0] TAKE_NUM,
	output logic TAKE_SECURE,
	input wire logic ENTRY_ACK,
	input wire logic RETURN_REQ,
	input wire logic [3:0] RETURN_SLOT,
	output logic [8:0] EXEC_PRIO
);

	// ------------------------------------------------------------
	// State.
	// ------------------------------------------------------------
	logic [31:0] config_r;
	logic [31:0] masks_r;
	logic [3:0] hcsr_en_r;
	logic [fcpa_pkg::NFLAG-1:0] flag_r, flag_nxt;
	logic [7:0] prio_r [fcpa_pkg::NSLOT];
	logic [fcpa_pkg::NSLOT-1:0] ns_r;
	logic [fcpa_pkg::NSLOT-1:0] pend_r, pend_nxt;
	logic [fcpa_pkg::NSLOT-1:0] act_r, act_nxt;
	logic hsec_r;
	logic bvalid_r, rvalid_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic take_req_r, take_sec_r;
	logic [3:0] take_slot_r;
	logic [8:0] take_num_r, exec_r;

	// ------------------------------------------------------------
	// Helpers.
	// ------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Group bits kept for a grouping value; without main the split is fixed.
	function automatic logic [7:0] grp_mask(input logic [2:0] sel);
		return MAIN_EXT ? (fcpa_pkg::GROUP_MASK_BASE << sel) : fcpa_pkg::GROUP_MASK_BASE;
	endfunction

	// Biased group key: value plus one, so the fixed hard fault sits at zero.
	function automatic logic [8:0] grp_key(input logic [7:0] pri, input logic dem);
		logic [8:0] g;
		g = {1'b0, pri & grp_mask(config_r[fcpa_pkg::CFG_GROUP_LSB +: 3])};
		if (dem) begin
			g = {2'b01, g[7:1]};
		end
		return g + 9'h001;
	endfunction

	// ------------------------------------------------------------
	// Decoding.
	// ------------------------------------------------------------
	wire wr_fire = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_r;
	wire rd_fire = S_AXI_ARVALID & ~rvalid_r;
	wire [11:0] waddr = S_AXI_AWADDR;
	wire [11:0] raddr = S_AXI_ARADDR;
	wire wr_cfg = wr_fire & (waddr == fcpa_pkg::OFS_CONFIG);
	wire wr_msk = wr_fire & (waddr == fcpa_pkg::OFS_MASKS);
	wire wr_fst = wr_fire & (waddr == fcpa_pkg::OFS_FSTAT);
	wire wr_hcs = wr_fire & (waddr == fcpa_pkg::OFS_HCSR);
	wire wr_pri = wr_fire & (waddr >= fcpa_pkg::OFS_PRIO_BASE) &
		(waddr <= fcpa_pkg::OFS_PRIO_LAST) & (waddr[1:0] == 2'b00);
	wire [3:0] wr_idx = 4'((waddr - fcpa_pkg::OFS_PRIO_BASE) >> 2);
	wire wr_ok = wr_cfg | wr_msk | wr_fst | wr_hcs | wr_pri | (waddr == fcpa_pkg::OFS_STATE) |
		(waddr == fcpa_pkg::OFS_EXSTATE);
	wire [31:0] wdata_m = merge(32'h0000_0000, S_AXI_WDATA, S_AXI_WSTRB);
	wire dem_on = MAIN_EXT & SEC_EXT & config_r[fcpa_pkg::CFG_DEMOTE_BIT];
	wire [7:0] impl_mask = MAIN_EXT ? fcpa_pkg::IMPL_MASK_MAIN : fcpa_pkg::IMPL_MASK_BASE;

	// ------------------------------------------------------------
	// Fault classification.
	// ------------------------------------------------------------
	logic [fcpa_pkg::NFLAG-1:0] cause;
	always_comb begin
		cause = FAULT_CAUSE;
		cause[fcpa_pkg::FL_BADSTATE] = FAULT_CAUSE[fcpa_pkg::FL_BADSTATE] |
			(INSTR_ISSUE & ~INSTRUCTION_SET_STATE_BIT);
		cause[fcpa_pkg::FL_MISALIGN] = FAULT_CAUSE[fcpa_pkg::FL_MISALIGN] &
			config_r[fcpa_pkg::CFG_MISALIGN_BIT];
		cause[fcpa_pkg::FL_ZDIV] = FAULT_CAUSE[fcpa_pkg::FL_ZDIV] &
			config_r[fcpa_pkg::CFG_ZDIV_BIT];
		if (!SEC_EXT) begin
			cause[fcpa_pkg::FL_SEC_LSB +: 7] = 7'h00;
		end
	end

	wire raise_bus = |cause[fcpa_pkg::FL_BUS_LSB +: 4];
	wire raise_use = |cause[fcpa_pkg::FL_USE_LSB +: 7];
	wire raise_sec = |cause[fcpa_pkg::FL_SEC_LSB +: 7];
	// A fault goes to its own handler only when enabled and not already active;
	// otherwise it escalates, so a synchronous slot is never both states.
	// A slot entered in this cycle already counts as active, so a cause in the
	// same cycle escalates instead of pending it again.
	wire take = ENTRY_ACK & take_req_r;
	wire [fcpa_pkg::NSLOT-1:0] entering = {{(fcpa_pkg::NSLOT-1){1'b0}}, take} << take_slot_r;
	wire [fcpa_pkg::NSLOT-1:0] busy = act_r | entering;
	wire to_bus = MAIN_EXT & raise_bus & hcsr_en_r[1] & ~busy[fcpa_pkg::SL_BUS];
	wire to_use = MAIN_EXT & raise_use & hcsr_en_r[2] & ~busy[fcpa_pkg::SL_USE];
	wire to_sec = MAIN_EXT & raise_sec & hcsr_en_r[3] & ~busy[fcpa_pkg::SL_SEC];
	wire to_hard = (raise_bus & ~to_bus) | (raise_use & ~to_use) | (raise_sec & ~to_sec);
	wire hard_sec = ~MAIN_EXT & raise_sec;
	wire [fcpa_pkg::NFLAG-1:0] flag_clr = wr_fst ? wdata_m[fcpa_pkg::NFLAG-1:0] :
		'0;

	// Set wins over a clear in the same cycle.
	always_comb begin
		flag_nxt = (flag_r & ~flag_clr) | (MAIN_EXT ? cause : '0);
	end

	// ------------------------------------------------------------
	// Exception states.
	// ------------------------------------------------------------
	always_comb begin
		pend_nxt = pend_r;
		act_nxt = act_r;
		if (take) begin
			pend_nxt[take_slot_r] = 1'b0;
			act_nxt[take_slot_r] = 1'b1;
		end
		if (RETURN_REQ && RETURN_SLOT < 4'(fcpa_pkg::NSLOT)) begin
			act_nxt[RETURN_SLOT] = 1'b0;
		end
		// Interrupts are asynchronous and may pend while active.
		pend_nxt[fcpa_pkg::SL_IRQ +: fcpa_pkg::NIRQ] = pend_nxt[fcpa_pkg::SL_IRQ +:
			fcpa_pkg::NIRQ] | IRQ_REQ;
		if (to_hard && !busy[fcpa_pkg::SL_HARD]) begin
			pend_nxt[fcpa_pkg::SL_HARD] = 1'b1;
		end
		if (to_bus) begin
			pend_nxt[fcpa_pkg::SL_BUS] = 1'b1;
		end
		if (to_use) begin
			pend_nxt[fcpa_pkg::SL_USE] = 1'b1;
		end
		if (to_sec) begin
			pend_nxt[fcpa_pkg::SL_SEC] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Priority keys, execution priority and arbitration.
	// ------------------------------------------------------------
	logic [8:0] gkey [fcpa_pkg::NSLOT];
	logic [7:0] skey [fcpa_pkg::NSLOT];
	always_comb begin
		for (int i = 0; i < fcpa_pkg::NSLOT; i++) begin
			gkey[i] = grp_key(prio_r[i], dem_on & ns_r[i]);
			skey[i] = (dem_on & ns_r[i]) ? 8'h00 :
				(prio_r[i] & ~grp_mask(config_r[fcpa_pkg::CFG_GROUP_LSB +: 3]));
		end
		gkey[fcpa_pkg::SL_HARD] = fcpa_pkg::KEY_HARD;
		skey[fcpa_pkg::SL_HARD] = 8'h00;
	end

	logic [8:0] act_min, exec_c, best_g;
	logic [7:0] best_s;
	logic [3:0] best_i;
	logic best_v, best_ns;
	wire [8:0] base_key = grp_key(masks_r[fcpa_pkg::MSK_BASE_LSB +: 8] & impl_mask, 1'b0);
	always_comb begin
		act_min = fcpa_pkg::KEY_IDLE;
		for (int i = 0; i < fcpa_pkg::NSLOT; i++) begin
			if (act_r[i] && gkey[i] < act_min) begin
				act_min = gkey[i];
			end
		end
		exec_c = act_min;
		if (MAIN_EXT && masks_r[fcpa_pkg::MSK_BASE_LSB +: 8] != 8'h00 && base_key < exec_c) begin
			exec_c = base_key;
		end
		if (masks_r[fcpa_pkg::MSK_GLOBAL_BIT] && fcpa_pkg::KEY_GLOBAL_PRIORITY_MASK < exec_c) begin
			exec_c = fcpa_pkg::KEY_GLOBAL_PRIORITY_MASK;
		end
		if (MAIN_EXT && masks_r[fcpa_pkg::MSK_FAULT_BIT]) begin
			exec_c = fcpa_pkg::KEY_FAULT_PRIORITY_MASK;
		end
	end

	// Slots are scanned in ascending exception number, so only a strictly
	// better key replaces the holder; a secure slot beats a non-secure one only when keys and exception number are equal.
	always_comb begin
		best_v = 1'b0;
		best_g = fcpa_pkg::KEY_IDLE;
		best_s = 8'hFF;
		best_i = 4'h0;
		best_ns = 1'b1;
		for (int i = 0; i < fcpa_pkg::NSLOT; i++) begin
			if (pend_r[i] && (!best_v || gkey[i] < best_g || (gkey[i] == best_g &&
				(skey[i] < best_s || (skey[i] == best_s && fcpa_pkg::slot_num(i) ==
				fcpa_pkg::slot_num(int'(best_i)) && best_ns && !ns_r[i]))))) begin
				best_v = 1'b1;
				best_g = gkey[i];
				best_s = skey[i];
				best_i = 4'(i);
				best_ns = ns_r[i];
			end
		end
	end
	wire take_c = best_v & (best_g < exec_c);

	// ------------------------------------------------------------
	// Register reads.
	// ------------------------------------------------------------
	wire [3:0] rd_idx = 4'((raddr - fcpa_pkg::OFS_PRIO_BASE) >> 2);
	wire rd_pri = (raddr >= fcpa_pkg::OFS_PRIO_BASE) & (raddr <= fcpa_pkg::OFS_PRIO_LAST) &
		(raddr[1:0] == 2'b00);
	wire [3:0] sys_pend = pend_r[fcpa_pkg::SL_MEM +: 4];
	wire [3:0] sys_act = act_r[fcpa_pkg::SL_MEM +: 4];
	wire [31:0] hcsr_rd = MAIN_EXT ? {20'h0_0000, sys_act, sys_pend, hcsr_en_r} :
		32'h0000_0000;
	wire [31:0] state_rd = {11'h000, hsec_r, take_req_r, best_v, fcpa_pkg::slot_num(int'(best_i)),
		exec_r};
	wire [31:0] exst_rd = {7'h00, act_r, 7'h00, pend_r};
	wire [31:0] prio_rd = rd_pri ? {23'h00_0000, ns_r[rd_idx], prio_r[rd_idx]} : 32'h0000_0000;
	wire rd_ok = rd_pri | (raddr == fcpa_pkg::OFS_CONFIG) | (raddr == fcpa_pkg::OFS_MASKS) |
		(raddr == fcpa_pkg::OFS_FSTAT) | (raddr == fcpa_pkg::OFS_HCSR) |
		(raddr == fcpa_pkg::OFS_STATE) | (raddr == fcpa_pkg::OFS_EXSTATE);
	wire [31:0] rd_val = (raddr == fcpa_pkg::OFS_CONFIG) ? config_r :
		(raddr == fcpa_pkg::OFS_MASKS) ? masks_r :
		(raddr == fcpa_pkg::OFS_FSTAT) ? {14'h0000, flag_r} :
		(raddr == fcpa_pkg::OFS_HCSR) ? hcsr_rd :
		(raddr == fcpa_pkg::OFS_STATE) ? state_rd :
		(raddr == fcpa_pkg::OFS_EXSTATE) ? exst_rd : prio_rd;

	// ------------------------------------------------------------
	// Registers.
	// ------------------------------------------------------------
	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			config_r <= fcpa_pkg::CONFIG_RST;
			masks_r <= fcpa_pkg::MASKS_RST;
			hcsr_en_r <= 4'h0;
		end else begin
			if (wr_cfg) begin
				config_r <= merge(config_r, S_AXI_WDATA, S_AXI_WSTRB) & 32'h0000_0707;
			end
			if (wr_msk) begin
				masks_r <= merge(masks_r, S_AXI_WDATA, S_AXI_WSTRB) &
					{16'h0000, impl_mask, 8'h03};
			end
			if (wr_hcs && MAIN_EXT) begin
				hcsr_en_r <= wdata_m[3:0] | (hcsr_en_r & ~{4{S_AXI_WSTRB[0]}});
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			for (int i = 0; i < fcpa_pkg::NSLOT; i++) begin
				prio_r[i] <= fcpa_pkg::PRIO_RST;
			end
			ns_r <= '0;
		end else if (wr_pri && wr_idx != 4'(fcpa_pkg::SL_HARD) && S_AXI_WSTRB[0]) begin
			prio_r[wr_idx] <= S_AXI_WDATA[7:0] & impl_mask;
			if (S_AXI_WSTRB[1]) begin
				ns_r[wr_idx] <= SEC_EXT & (wr_idx != 4'(fcpa_pkg::SL_SEC)) &
					S_AXI_WDATA[fcpa_pkg::PRIO_NS_BIT];
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			flag_r <= '0;
			pend_r <= '0;
			act_r <= '0;
			hsec_r <= 1'b0;
		end else begin
			flag_r <= flag_nxt;
			pend_r <= pend_nxt;
			act_r <= act_nxt;
			if (hard_sec) begin
				hsec_r <= 1'b1;
			end else if (take && take_slot_r == 4'(fcpa_pkg::SL_HARD)) begin
				hsec_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			take_req_r <= 1'b0;
			take_slot_r <= 4'h0;
			take_num_r <= 9'h000;
			take_sec_r <= 1'b0;
			exec_r <= fcpa_pkg::KEY_IDLE;
		end else begin
			take_req_r <= take_c & ~take & ~(to_hard | to_bus | to_use | to_sec);
			take_slot_r <= best_i;
			take_num_r <= fcpa_pkg::slot_num(int'(best_i));
			take_sec_r <= ~best_ns | ((best_i == 4'(fcpa_pkg::SL_HARD)) & (hsec_r | hard_sec));
			exec_r <= exec_c;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bvalid_r <= 1'b0;
			bresp_r <= fcpa_pkg::RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= fcpa_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_ok ? fcpa_pkg::RESP_OKAY : fcpa_pkg::RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				bvalid_r <= 1'b0;
			end
			if (rd_fire) begin
				rvalid_r <= 1'b1;
				rresp_r <= rd_ok ? fcpa_pkg::RESP_OKAY : fcpa_pkg::RESP_SLVERR;
				rdata_r <= rd_ok ? rd_val : 32'h0000_0000;
			end else if (S_AXI_RREADY) begin
				rvalid_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs.
	// ------------------------------------------------------------
	assign S_AXI_AWREADY = wr_fire;
	assign S_AXI_WREADY = wr_fire;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_ARREADY = rd_fire;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RRESP = rresp_r;
	assign S_AXI_RDATA = rdata_r;
	assign TAKE_REQ = take_req_r;
	assign TAKE_SLOT = take_slot_r;
	assign TAKE_NUM = take_num_r;
	assign TAKE_SECURE = take_sec_r;
	assign EXEC_PRIO = exec_r;

	// ------------------------------------------------------------
	// Checks.
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESET_N);

	sequence s_flag_held(int k);
		flag_r[k] && !(wr_fst && wdata_m[k]);
	endsequence

	sequence s_write_taken;
		wr_fire ##1 bvalid_r;
	endsequence

	chk_flag_sticky_hold: assert property (s_flag_held(0) |=> flag_r[0])
		else $error("bus flag dropped without a clear");
	chk_trap_gate_off: assert property (!config_r[fcpa_pkg::CFG_MISALIGN_BIT] &&
		!flag_r[fcpa_pkg::FL_MISALIGN] && !wr_cfg |=> !flag_r[fcpa_pkg::FL_MISALIGN])
		else $error("misaligned flag set with trap disabled");
	chk_sync_never_both: assert property ((pend_r[fcpa_pkg::SL_HARD +: 5] &
		act_r[fcpa_pkg::SL_HARD +: 5]) == 5'h00)
		else $error("synchronous fault active and pending");
	chk_idle_prio_level: assert property (act_r == '0 && masks_r == '0 |=>
		$past(exec_c) == fcpa_pkg::KEY_IDLE && exec_r == fcpa_pkg::KEY_IDLE)
		else $error("idle execution priority wrong");
	chk_preempt_strict_less: assert property (take_req_r |-> $past(best_g) < $past(exec_c))
		else $error("preemption without strictly smaller group");
	chk_handler_control_state_reg_no_main: assert property (!MAIN_EXT |-> hcsr_rd == 32'h0000_0000)
		else $error("handler control bits visible without main");
	chk_bus_fault_pend: assert property (to_bus |=> pend_r[fcpa_pkg::SL_BUS] &&
		flag_r[fcpa_pkg::FL_BUS_LSB +: 4] != 4'h0)
		else $error("bus fault not raised");
	chk_secure_to_hard: assert property (hard_sec |=> hsec_r &&
		(pend_r[fcpa_pkg::SL_HARD] || act_r[fcpa_pkg::SL_HARD]))
		else $error("secure cause did not reach hard fault");
	chk_prio_low_zero: assert property ((prio_r[fcpa_pkg::SL_IRQ] & ~impl_mask) == 8'h00)
		else $error("unimplemented priority bits set");
	chk_write_resp_next: assert property (s_write_taken |->
		(bresp_r == fcpa_pkg::RESP_OKAY) == $past(wr_ok))
		else $error("write response code wrong");

endmodule

`default_nettype wire

/* File: verification/fcpa_core.sv */
// Behavioural model of the core that raises causes and takes exceptions.
`timescale 1ns/10ps
`default_nettype none
module fcpa_core (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst_n,
	// Control from the bench.
	input wire logic ack_en,
	input wire logic [3:0] ack_dly,
	// Exception entry and return.
	input wire logic take_req,
	output logic entry_ack,
	output logic return_req,
	output logic [3:0] return_slot,
	// Causes.
	output logic [17:0] fault_cause,
	output logic instr_issue,
	output logic state_bit,
	output logic [3:0] irq_req
);
	logic [3:0] cnt_r;
	logic go;
	assign go = ack_en && take_req && !entry_ack;
	initial begin
		return_req = 1'b0;
		return_slot = 4'h0;
		fault_cause = '0;
		instr_issue = 1'b0;
		state_bit = 1'b1;
		irq_req = 4'h0;
	end
	// -------------------------------------------
	// Entry is accepted after a set number of cycles.
	// -------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 4'h0;
			entry_ack <= 1'b0;
		end else begin
			entry_ack <= go && cnt_r == ack_dly;
			cnt_r <= (go && cnt_r != ack_dly) ? cnt_r + 4'h1 : 4'h0;
		end
	end
	task automatic pulse(input logic [17:0] c, input logic [3:0] m);
		fault_cause <= c;
		irq_req <= m;
		@(posedge clk);
		fault_cause <= '0;
		irq_req <= 4'h0;
	endtask
	task automatic ret(input logic [3:0] s);
		return_slot <= s;
		return_req <= 1'b1;
		@(posedge clk);
		return_req <= 1'b0;
	endtask
	task automatic issue(input logic t);
		state_bit <= t;
		instr_issue <= 1'b1;
		@(posedge clk);
		instr_issue <= 1'b0;
		state_bit <= 1'b1;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

/* File: verification/fault_classify_priority_arbiter_tb.sv */
// Self-checking bench for the fault classifier and priority arbiter.
`timescale 1ns/10ps
`default_nettype none
module fault_classify_priority_arbiter_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, v;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, bvalid, arready, rvalid, take_req, ack, rq, iss, sb, wready, tsec;
	logic ack_en = 1'b1;
	logic [3:0] ack_dly = 4'h0, irq, rs, tslot;
	logic [1:0] bresp, rresp, r;
	logic [17:0] fc;
	logic [8:0] tnum, xp;
	logic [31:0] mval [3] = '{32'h0000_8000, 32'h0000_0001, 32'h0000_0002};
	logic [8:0] mexp [3] = '{9'h081, 9'h001, 9'h000};
	int fbit [3] = '{0, 4, 11};
	int fail_count = 0, checks_done = 0;
	initial forever #12.5 clk = ~clk;
	fcpa_top fcpa_top_i (
		.SYS_CLK(clk), .RESET_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.FAULT_CAUSE(fc), .INSTR_ISSUE(iss), .INSTRUCTION_SET_STATE_BIT(sb), .IRQ_REQ(irq),
		.TAKE_REQ(take_req), .TAKE_SLOT(tslot), .TAKE_NUM(tnum), .TAKE_SECURE(tsec),
		.ENTRY_ACK(ack), .RETURN_REQ(rq), .RETURN_SLOT(rs), .EXEC_PRIO(xp)
	);
	fcpa_core fcpa_core_i (
		.clk(clk), .rst_n(rst_n), .ack_en(ack_en), .ack_dly(ack_dly), .take_req(take_req),
		.entry_ack(ack), .return_req(rq), .return_slot(rs), .fault_cause(fc),
		.instr_issue(iss), .state_bit(sb), .irq_req(irq)
	);
	// -------------------------------------------
	// Bus tasks and result reporting.
	// -------------------------------------------
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic ck(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	function automatic logic sg(input int k);
		return k == 0 ? awready & wready : k == 1 ? bvalid : k == 2 ? arready :
			k == 3 ? rvalid : take_req;
	endfunction
	task automatic wt(input int k);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (sg(k) !== 1'b1 && n < 200);
		if (sg(k) !== 1'b1) begin
			fail_count++;
			end_sim();
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		wt(0);
		@(posedge clk);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		bready <= 1'b1;
		wt(1);
		r = bresp;
		@(posedge clk);
		bready <= 1'b0;
	endtask
	task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
		araddr <= a;
		arvalid <= 1'b1;
		wt(2);
		@(posedge clk);
		arvalid <= 1'b0;
		rready <= 1'b1;
		wt(3);
		v = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
		ck(nm, v, e);
	endtask
	task automatic rst();
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
	endtask
	// -------------------------------------------
	// Scenarios.
	// -------------------------------------------
	initial begin
		rst();
		ck("exec_idle", xp, 9'h101);
		rc("exstate", fcpa_pkg::OFS_EXSTATE, 32'h0000_0000);
		wr(fcpa_pkg::OFS_PRIO_BASE + 12'h008, 32'h0000_00FF);
		rc("prio_bits", fcpa_pkg::OFS_PRIO_BASE + 12'h008, 32'h0000_00F0);
		wr(12'h100, 32'h0000_0001);
		ck("wr_unmapped", r, fcpa_pkg::RESP_SLVERR);
		rc("rd_unmapped", 12'h100, 32'h0000_0000);
		ck("rd_unmapped_resp", r, fcpa_pkg::RESP_SLVERR);
		for (int i = 0; i < 3; i++) begin
			wr(fcpa_pkg::OFS_MASKS, mval[i]);
			repeat (3) @(posedge clk);
			ck("exec_mask", xp, mexp[i]);
		end
		rst();
		wr(fcpa_pkg::OFS_HCSR, 32'h0000_000F);
		for (int i = 0; i < 3; i++) begin
			fcpa_core_i.pulse(18'h0_0001 << fbit[i], 4'h0);
			wt(4);
			ck("fault_num", tnum, 9'(5 + i));
			ck("fault_slot", tslot, 4'(2 + i));
			repeat (6) @(posedge clk);
			ck("fault_exec", xp, 9'h001);
			fcpa_core_i.ret(4'(2 + i));
		end
		rc("flags_kept", fcpa_pkg::OFS_FSTAT, 32'h0000_0811);
		wr(fcpa_pkg::OFS_FSTAT, 32'h0000_0001);
		fcpa_core_i.pulse(18'h0_0200, 4'h0);
		rc("trap_off", fcpa_pkg::OFS_FSTAT, 32'h0000_0810);
		wr(fcpa_pkg::OFS_CONFIG, 32'h0000_0003);
		fcpa_core_i.pulse(18'h0_0200, 4'h0);
		repeat (6) @(posedge clk);
		fcpa_core_i.pulse(18'h0_0400, 4'h0);
		wt(4);
		ck("escalate", tnum, fcpa_pkg::EXC_HARD);
		fcpa_core_i.issue(1'b1);
		fcpa_core_i.issue(1'b0);
		rc("flags_all", fcpa_pkg::OFS_FSTAT, 32'h0000_0E30);
		rst();
		ack_en <= 1'b0;
		ack_dly <= 4'h3;
		wr(fcpa_pkg::OFS_CONFIG, 32'h0000_0500);
		wr(fcpa_pkg::OFS_PRIO_BASE + 12'h014, 32'h0000_0060);
		wr(fcpa_pkg::OFS_PRIO_BASE + 12'h018, 32'h0000_0040);
		fcpa_core_i.pulse(18'h0_0000, 4'h3);
		wt(4);
		ck("sub_wins", tnum, 9'h011);
		ack_en <= 1'b1;
		repeat (10) @(posedge clk);
		ck("same_group", take_req, 1'b0);
		ck("group_exec", xp, 9'h041);
		fcpa_core_i.ret(4'h6);
		wt(4);
		ck("next_pick", tnum, 9'h010);
		rst();
		ack_en <= 1'b0;
		wr(fcpa_pkg::OFS_CONFIG, 32'h0000_0004);
		wr(fcpa_pkg::OFS_PRIO_BASE + 12'h01C, 32'h0000_0140);
		wr(fcpa_pkg::OFS_PRIO_BASE + 12'h020, 32'h0000_0090);
		fcpa_core_i.pulse(18'h0_0000, 4'hC);
		wt(4);
		ck("demoted", tnum, 9'h013);
		ck("demoted_slot", tslot, 4'h8);
		ck("demoted_sec", tsec, 1'b1);
		end_sim();
	end
endmodule
`default_nettype wire
